/* hdl/nnd_core.v */
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`include "nnd_defs.vh"
`default_nettype none

module nnd_core #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  output wire [11:0]       mem_addr,
  output wire              mem_rd_en,
  input  wire [7:0]        mem_rd_data,
  output wire              mem_wr_en,
  output wire [7:0]        mem_wr_data
);

  // ----------------------------------------------------------------------
  // phase sequencer states
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_Q1   = 3'd1;
  localparam ST_Q2   = 3'd2;
  localparam ST_Q3   = 3'd3;
  localparam ST_Q4   = 3'd4;

  reg  [2:0]        state_q;
  reg  [15:0]       opcode_q;
  reg  [3:0]        bank_select_register_q;
  reg               ext_en_q;
  reg  [11:0]       index_base_q;
  reg  [4:0]        flags_q;
  reg               unsup_q;
  reg               is_neg_q;
  reg  [11:0]       mem_addr_q;
  reg               mem_rd_en_q;
  reg               mem_wr_en_q;
  reg  [7:0]        mem_wr_data_q;

  reg               aw_got_q;
  reg  [ADDR_W-1:0] awaddr_q;
  reg               w_got_q;
  reg  [31:0]       wdata_q;
  reg  [3:0]        wstrb_q;
  reg               bvalid_q;
  reg  [1:0]        bresp_q;
  reg               rvalid_q;
  reg  [31:0]       rdata_q;
  reg  [1:0]        rresp_q;

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  // accept address and data in either order, one write in flight
  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ~w_got_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  wire do_write = aw_got_q & w_got_q & ~bvalid_q;
  wire busy     = (state_q != ST_IDLE);

  wire wr_opcode = do_write & (awaddr_q == `NND_OFF_OPCODE);
  wire wr_bank   = do_write & (awaddr_q == `NND_OFF_BANK_SEL);
  wire wr_cfg    = do_write & (awaddr_q == `NND_OFF_CONFIG);
  wire wr_index  = do_write & (awaddr_q == `NND_OFF_INDEX_BASE);
  wire wr_status = do_write & (awaddr_q == `NND_OFF_STATUS);
  wire wr_hit    = wr_opcode | wr_bank | wr_cfg | wr_index | wr_status;

  // an opcode write while busy is dropped so the running instruction is intact
  wire start = wr_opcode & ~busy & (wstrb_q[0] | wstrb_q[1]);

  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] op_merged = ({16'h0000, opcode_q} & ~wmask) | (wdata_q & wmask);
  wire [31:0] ix_merged = ({20'h0_0000, index_base_q} & ~wmask) | (wdata_q & wmask);

  // bus handshake flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      w_got_q  <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `NND_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? `NND_RESP_OKAY : `NND_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  reg [31:0] rd_mux;
  reg        rd_hit;

  // read decode; unused bits read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `NND_OFF_OPCODE:     rd_mux = {16'h0000, opcode_q};
      `NND_OFF_BANK_SEL:   rd_mux = {28'h000_0000, bank_select_register_q};
      `NND_OFF_CONFIG:     rd_mux = {31'h0000_0000, ext_en_q};
      `NND_OFF_INDEX_BASE: rd_mux = {20'h0_0000, index_base_q};
      `NND_OFF_STATUS:     rd_mux = {22'h00_0000, unsup_q, busy, 3'h0, flags_q};
      default:             rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `NND_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? `NND_RESP_OKAY : `NND_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // decode and operand address
  // ----------------------------------------------------------------------
  wire       dec_neg   = (opcode_q[15:9] == `NND_NEG_PATTERN);
  wire       dec_idle  = (opcode_q == `NND_IDLE_ZERO) |
                         (opcode_q[15:12] == `NND_IDLE_NIBBLE);
  wire       acc_bit   = opcode_q[8];
  wire [7:0] file_f    = opcode_q[7:0];
  wire       use_index = ~acc_bit & ext_en_q & (file_f <= `NND_INDEX_LIMIT);

  reg [11:0] op_addr;

  // low half of the access bank is ram, high half maps onto the top sfr bank
  always @* begin
    if (acc_bit) begin
      op_addr = {bank_select_register_q, file_f};
    end else if (use_index) begin
      op_addr = index_base_q + {4'h0, file_f};
    end else if (file_f < `NND_ACC_SPLIT) begin
      op_addr = {`NND_LOW_BANK, file_f};
    end else begin
      op_addr = {`NND_SFR_BANK, file_f};
    end
  end

  // ----------------------------------------------------------------------
  // negate datapath
  // ----------------------------------------------------------------------
  wire [7:0] neg_result;
  wire       neg_n;
  wire       neg_overflow;
  wire       neg_z;
  wire       neg_digit_carry;
  wire       neg_c;

  nnd_negate_alu nnd_negate_alu_inst (
    .operand          (mem_rd_data),
    .result           (neg_result),
    .flag_n           (neg_n),
    .overflow_flag    (neg_overflow),
    .flag_z           (neg_z),
    .digit_carry_flag (neg_digit_carry),
    .flag_c           (neg_c)
  );

  // ----------------------------------------------------------------------
  // four phase sequencer: decode, read, process, write
  // ----------------------------------------------------------------------
  assign mem_addr    = mem_addr_q;
  assign mem_rd_en   = mem_rd_en_q;
  assign mem_wr_en   = mem_wr_en_q;
  assign mem_wr_data = mem_wr_data_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q       <= ST_IDLE;
      is_neg_q      <= 1'b0;
      mem_addr_q    <= 12'h000;
      mem_rd_en_q   <= 1'b0;
      mem_wr_en_q   <= 1'b0;
      mem_wr_data_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_Q1;
          end
        end
        ST_Q1: begin
          // idle and unknown opcodes run all four phases with no access
          is_neg_q    <= dec_neg & ~dec_idle;
          mem_addr_q  <= op_addr;
          mem_rd_en_q <= dec_neg;
          state_q     <= ST_Q2;
        end
        ST_Q2: begin
          mem_rd_en_q <= 1'b0;
          state_q     <= ST_Q3;
        end
        ST_Q3: begin
          // read data arrives one cycle after the read strobe
          mem_wr_en_q   <= is_neg_q;
          mem_wr_data_q <= neg_result;
          state_q       <= ST_Q4;
        end
        ST_Q4: begin
          mem_wr_en_q <= 1'b0;
          state_q     <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // software visible registers
  // ----------------------------------------------------------------------
  wire set_unsup = (state_q == ST_Q1) & ~dec_neg & ~dec_idle;
  wire clr_unsup = wr_status & wstrb_q[1] & wdata_q[`NND_ST_UNSUP];
  wire hw_flags  = (state_q == ST_Q3) & is_neg_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      opcode_q               <= `NND_RST_OPCODE;
      bank_select_register_q <= `NND_RST_BANK_SEL;
      ext_en_q               <= 1'b0;
      index_base_q           <= `NND_RST_INDEX_BASE;
      flags_q                <= `NND_RST_FLAGS;
      unsup_q                <= 1'b0;
    end else begin
      if (start) begin
        opcode_q <= op_merged[15:0];
      end
      if (wr_bank && wstrb_q[0]) begin
        bank_select_register_q <= wdata_q[3:0];
      end
      if (wr_cfg && wstrb_q[0]) begin
        ext_en_q <= wdata_q[`NND_CFG_EXT];
      end
      if (wr_index) begin
        index_base_q <= ix_merged[11:0];
      end
      // the instruction's own flag update beats a software write
      if (hw_flags) begin
        flags_q <= {neg_n, neg_overflow, neg_z, neg_digit_carry, neg_c};
      end else if (wr_status && wstrb_q[0] && !busy) begin
        flags_q <= wdata_q[4:0];
      end
      // set wins over a clear in the same cycle
      if (set_unsup) begin
        unsup_q <= 1'b1;
      end else if (clr_unsup) begin
        unsup_q <= 1'b0;
      end
    end
  end

endmodule // nnd_core

`default_nettype wire

/* hdl/nnd_defs.vh */
`ifndef NND_DEFS_VH
`define NND_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define NND_OFF_OPCODE      8'h00
`define NND_OFF_BANK_SEL    8'h04
`define NND_OFF_CONFIG      8'h08
`define NND_OFF_INDEX_BASE  8'h0C
`define NND_OFF_STATUS      8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define NND_ST_C            0
`define NND_ST_DIGIT_CARRY  1
`define NND_ST_Z            2
`define NND_ST_OVERFLOW     3
`define NND_ST_N            4
`define NND_ST_BUSY         8
`define NND_ST_UNSUP        9
`define NND_CFG_EXT         0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define NND_RST_OPCODE      16'h0000
`define NND_RST_BANK_SEL    4'h0
`define NND_RST_INDEX_BASE  12'h000
`define NND_RST_FLAGS       5'h00

// ----------------------------------------------------------------------
// instruction encodings and address map
// ----------------------------------------------------------------------
`define NND_NEG_PATTERN     7'h36
`define NND_IDLE_ZERO       16'h0000
`define NND_IDLE_NIBBLE     4'hF
`define NND_ACC_SPLIT       8'h80
`define NND_SFR_BANK        4'hF
`define NND_LOW_BANK        4'h0
`define NND_INDEX_LIMIT     8'h5F

// ----------------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------------
`define NND_RESP_OKAY       2'h0
`define NND_RESP_SLVERR     2'h2

`endif

/* hdl/nnd_negate_alu.v */
`include "nnd_defs.vh"
`default_nettype none

// ----------------------------------------------------------------------
// two's complement negate with status flags
// ----------------------------------------------------------------------
module nnd_negate_alu (
  input  wire [7:0] operand,
  output wire [7:0] result,
  output wire       flag_n,
  output wire       overflow_flag,
  output wire       flag_z,
  output wire       digit_carry_flag,
  output wire       flag_c
);

  wire [8:0] sum;
  wire [4:0] low_sum;

  // invert then add one; carry out only when the operand was zero
  assign sum              = {1'b0, ~operand} + 9'h001;
  assign low_sum          = {1'b0, ~operand[3:0]} + 5'h01;
  assign result           = sum[7:0];
  assign flag_c           = sum[8];
  assign digit_carry_flag = low_sum[4];
  assign flag_n           = sum[7];
  assign flag_z           = (sum[7:0] == 8'h00);
  // only the most negative value overflows when negated
  assign overflow_flag    = (operand == `NND_ACC_SPLIT);

endmodule // nnd_negate_alu

`default_nettype wire

/* verification/nnd_core_props.sv */
`default_nettype none

module nnd_core_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd_en,
  input wire logic [7:0]  mem_rd_data,
  input wire logic        mem_wr_en,
  input wire logic [7:0]  mem_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------------
  // negate sequencing and write response hold
  // ----------------------------------------------------------------------
  AST_RD_THEN_WR: assert property (mem_rd_en |-> ##2 mem_wr_en)
    else $error("read not followed by write back");
  AST_WR_VALUE: assert property (mem_wr_en |->
    mem_wr_data == 8'(~$past(mem_rd_data) + 8'h01))
    else $error("written byte is not the negated operand");
  AST_SAME_ADDR: assert property (mem_wr_en |-> mem_addr == $past(mem_addr, 2))
    else $error("write back address differs from read address");
  // a write with no read before it would be an idle opcode touching memory
  AST_NO_LONE_WR: assert property (mem_wr_en |-> $past(mem_rd_en, 2))
    else $error("memory write without operand read");
  AST_ONE_READ: assert property (mem_rd_en |=> !mem_rd_en [*3])
    else $error("more than one read per instruction");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before handshake");
endmodule // nnd_core_props

bind nnd_core nnd_core_props nnd_core_props_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
  .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data)
);

`default_nettype wire

/* verification/nnd_core_test.sv */
`include "nnd_defs.vh"
`default_nettype none

module nnd_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, awready, wready, bvalid, arready, rvalid, rd_en, wr_en;
  logic [7:0]  awaddr = 0, araddr = 0, rd_data, wr_data;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp;
  logic [11:0] addr;
  int          err_count = 0, comparisons = 0, wr_seen = 0;

  always #5 aclk = ~aclk;
  always @(posedge aclk) if (wr_en === 1'b1) wr_seen++;

  nnd_core nnd_core_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mem_addr(addr), .mem_rd_en(rd_en), .mem_rd_data(rd_data),
    .mem_wr_en(wr_en), .mem_wr_data(wr_data));
  nnd_mem_model nnd_mem_model_inst (.aclk(aclk), .mem_addr(addr), .mem_rd_en(rd_en),
    .mem_wr_en(wr_en), .mem_wr_data(wr_data), .mem_rd_data(rd_data));

  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // address and data released independently as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad = 0, wd = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 0;
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    d = rdata;
    r = rresp;
  endtask

  // polls busy; a hang here is caught by the watchdog
  task automatic run(input logic [15:0] op, output logic [31:0] st);
    logic [1:0] r;
    wr(`NND_OFF_OPCODE, op, `NND_RESP_OKAY);
    do rd(`NND_OFF_STATUS, st, r); while (st[`NND_ST_BUSY] !== 1'b0);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_bank;
    logic [31:0] st;
    nnd_mem_model_inst.mem[12'h33a] = 8'h3a;
    nnd_mem_model_inst.mem[12'h03a] = 8'h11;
    wr(`NND_OFF_BANK_SEL, 4'h3, `NND_RESP_OKAY);
    run(16'h6d3a, st);
    chk("banked byte", 8'hc6, nnd_mem_model_inst.mem[12'h33a]);
    chk("access byte", 8'h11, nnd_mem_model_inst.mem[12'h03a]);
    chk("flags", 5'h10, st[4:0]);
    $display("t_bank done");
  endtask

  task automatic t_access;
    logic [31:0] st;
    int          n = wr_seen;
    nnd_mem_model_inst.mem[12'hf85] = 8'h80;
    nnd_mem_model_inst.mem[12'h010] = 8'h00;
    run(16'h6c85, st);
    chk("high access byte", 8'h80, nnd_mem_model_inst.mem[12'hf85]);
    chk("flags overflow", 5'h1a, st[4:0]);
    run(16'h6c10, st);
    chk("low access byte", 8'h00, nnd_mem_model_inst.mem[12'h010]);
    chk("flags zero", 5'h07, st[4:0]);
    // both bytes negate to themselves, so count the write backs as well
    chk("negate writes", n + 2, wr_seen);
    $display("t_access done");
  endtask

  task automatic t_indexed;
    logic [31:0] st;
    nnd_mem_model_inst.mem[12'h25f] = 8'h01;
    nnd_mem_model_inst.mem[12'h060] = 8'h02;
    wr(`NND_OFF_CONFIG, 1, `NND_RESP_OKAY);
    wr(`NND_OFF_INDEX_BASE, 12'h200, `NND_RESP_OKAY);
    run(16'h6c5f, st);
    chk("indexed byte", 8'hff, nnd_mem_model_inst.mem[12'h25f]);
    run(16'h6c60, st);
    chk("above limit byte", 8'hfe, nnd_mem_model_inst.mem[12'h060]);
    wr(`NND_OFF_CONFIG, 0, `NND_RESP_OKAY);
    $display("t_indexed done");
  endtask

  task automatic t_idle;
    logic [31:0] st, d;
    logic [15:0] ops [3] = '{16'h0000, 16'hf123, 16'hffff};
    logic [1:0]  r;
    int          n = wr_seen;
    foreach (ops[i]) begin
      run(ops[i], st);
      chk("idle flags", 10'h010, st[9:0]);
    end
    chk("idle writes", n, wr_seen);
    run(16'h1234, st);
    chk("unsupported", 1'b1, st[`NND_ST_UNSUP]);
    rd(8'h20, d, r);
    chk("unmapped read", `NND_RESP_SLVERR, r);
    wr(8'h24, 0, `NND_RESP_SLVERR);
    $display("t_idle done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // whole run needs under two hundred cycles; far beyond that means a hang
  initial begin
    #50000;
    err_count++;
    conclude;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    t_bank;
    t_access;
    t_indexed;
    t_idle;
    conclude;
  end
endmodule // nnd_core_test

`default_nettype wire

/* verification/nnd_mem_model.sv */
`default_nettype none

module nnd_mem_model (
  input wire logic        aclk,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd_en,
  input wire logic        mem_wr_en,
  input wire logic [7:0]  mem_wr_data,
  output var logic [7:0]  mem_rd_data = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:4095];

  // byte shows one cycle after the strobe, then toggles every cycle so data one cycle stale reads inverted
  always @(posedge aclk) begin
    if (mem_rd_en) begin
      mem_rd_data <= mem[mem_addr];
    end else begin
      mem_rd_data <= ~mem_rd_data;
    end
    if (mem_wr_en) begin
      mem[mem_addr] <= mem_wr_data;
    end
  end
endmodule // nnd_mem_model

`default_nettype wire
